// ===== src/piso_pkg.sv
// Package: shared types and constants for the parallel-in serial-out shifter
package piso_pkg;

    // ********************************
    // Sizes and reset values
    // ********************************
    localparam int           STAGES      = 8;
    localparam logic [7:0]   STAGE_RST   = 8'h00;
    localparam logic [1:0]   SYNC_RST    = 2'h0;
    localparam int           SYNC_DEPTH  = 2;
    localparam logic [1:0]   OUT_RST     = 2'h1;
    localparam logic         COMB_RST    = 1'b0;

    // ********************************
    // Carriers
    // ********************************
    typedef struct packed {
        logic       load_n;
        logic       shift_clk;
        logic       shift_clk_alt;
        logic       serial_data_in;
    } piso_ctrl_type;

    typedef struct packed {
        logic       q_true;
        logic       q_comp;
    } piso_out_type;

    typedef enum logic [1:0] {
        PISO_LOAD  = 2'b00,
        PISO_SHIFT = 2'b01,
        PISO_HOLD  = 2'b10
    } piso_mode_type;

endpackage

// ===== src/piso_sync.sv
// Two-flop synchroniser for one asynchronous pin level
`timescale 1ns/1ps
module piso_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Pin level in, synchronised level out
    input  wire logic pin_in,
    output logic      level_out
);

    logic [piso_pkg::SYNC_DEPTH-1:0] sync_q;
    logic [piso_pkg::SYNC_DEPTH-1:0] sync_d;

    always_comb begin
        sync_d = {sync_q[piso_pkg::SYNC_DEPTH-2:0], pin_in};
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_q <= piso_pkg::SYNC_RST;
        end else begin
            sync_q <= sync_d;
        end
    end

    // Only the second flop is visible outside
    assign level_out = sync_q[piso_pkg::SYNC_DEPTH-1];

endmodule

// ===== src/piso_shifter.sv
// Eight-stage parallel-load, serial-shift register with complementary output
//
// Functional notes
// - Load-select low: all eight stages follow the parallel inputs, no edge needed.
// - Load-select high: each clock rise shifts, serial input enters first stage.
// - Either clock input causes an identical shift on its rising edge.
// - Either clock input held high blocks the other; stages hold.
// - State is static; clocking may pause or run arbitrarily slowly.
// - Eighth stage drives a true output and a complemented output.
`timescale 1ns/1ps
module piso_shifter (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    // Pin-level control and serial data
    input  wire piso_pkg::piso_ctrl_type ctrl,
    // Parallel data, bit 0 is stage A, bit 7 is stage H
    input  wire logic [7:0]             par_data,
    // Last-stage outputs
    output piso_pkg::piso_out_type      q_out
);

    // ********************************
    // Input synchronisation
    // ********************************
    // Pins are asynchronous to clk, so every one passes two flops first.
    // Cost: three clk cycles from pin to output; pin pulses shorter
    // than one cycle may be lost, so the controller holds levels longer.
    logic                load_n_s;
    logic                clk_a_s;
    logic                clk_b_s;
    logic                sdi_s;
    logic [7:0]          par_s;

    piso_sync u_sync_load (
        .clk       (clk),
        .arst_n    (arst_n),
        .pin_in    (ctrl.load_n),
        .level_out (load_n_s)
    );

    piso_sync u_sync_clka (
        .clk       (clk),
        .arst_n    (arst_n),
        .pin_in    (ctrl.shift_clk),
        .level_out (clk_a_s)
    );

    piso_sync u_sync_clkb (
        .clk       (clk),
        .arst_n    (arst_n),
        .pin_in    (ctrl.shift_clk_alt),
        .level_out (clk_b_s)
    );

    piso_sync u_sync_sdi (
        .clk       (clk),
        .arst_n    (arst_n),
        .pin_in    (ctrl.serial_data_in),
        .level_out (sdi_s)
    );

    piso_sync u_sync_par0 (
        .clk       (clk),
        .arst_n    (arst_n),
        .pin_in    (par_data[0]),
        .level_out (par_s[0])
    );

    piso_sync u_sync_par1 (
        .clk       (clk),
        .arst_n    (arst_n),
        .pin_in    (par_data[1]),
        .level_out (par_s[1])
    );

    piso_sync u_sync_par2 (
        .clk       (clk),
        .arst_n    (arst_n),
        .pin_in    (par_data[2]),
        .level_out (par_s[2])
    );

    piso_sync u_sync_par3 (
        .clk       (clk),
        .arst_n    (arst_n),
        .pin_in    (par_data[3]),
        .level_out (par_s[3])
    );

    piso_sync u_sync_par4 (
        .clk       (clk),
        .arst_n    (arst_n),
        .pin_in    (par_data[4]),
        .level_out (par_s[4])
    );

    piso_sync u_sync_par5 (
        .clk       (clk),
        .arst_n    (arst_n),
        .pin_in    (par_data[5]),
        .level_out (par_s[5])
    );

    piso_sync u_sync_par6 (
        .clk       (clk),
        .arst_n    (arst_n),
        .pin_in    (par_data[6]),
        .level_out (par_s[6])
    );

    piso_sync u_sync_par7 (
        .clk       (clk),
        .arst_n    (arst_n),
        .pin_in    (par_data[7]),
        .level_out (par_s[7])
    );

    // ********************************
    // Synchronised pin record
    // ********************************
    piso_pkg::piso_ctrl_type pins_s;

    always_comb begin
        pins_s.load_n         = load_n_s;
        pins_s.shift_clk      = clk_a_s;
        pins_s.shift_clk_alt  = clk_b_s;
        pins_s.serial_data_in = sdi_s;
    end

    // ********************************
    // Clock-edge detection
    // ********************************
    // The two shift clocks act as one NOR-combined clock: the internal
    // clock rises when the combined level falls, i.e. when one input rises
    // with the other low.
    logic                comb_q;
    logic                comb_d;
    logic                comb_now;
    logic                shift_edge;

    always_comb begin
        comb_now   = pins_s.shift_clk | pins_s.shift_clk_alt;
        comb_d     = comb_now;
        // A rise with the other held high leaves comb unchanged: no shift
        shift_edge = comb_now & ~comb_q;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            comb_q <= piso_pkg::COMB_RST;
        end else begin
            comb_q <= comb_d;
        end
    end

    // ********************************
    // Stage register
    // ********************************
    logic [7:0]              stage_q;
    logic [7:0]              stage_d;
    piso_pkg::piso_mode_type mode;

    always_comb begin
        stage_d = stage_q;
        if (!pins_s.load_n) begin
            mode = piso_pkg::PISO_LOAD;
        end else if (shift_edge) begin
            mode = piso_pkg::PISO_SHIFT;
        end else begin
            mode = piso_pkg::PISO_HOLD;
        end
        case (mode)
            piso_pkg::PISO_LOAD: begin
                stage_d = par_s;
            end
            piso_pkg::PISO_SHIFT: begin
                stage_d[0] = pins_s.serial_data_in;
                stage_d[1] = stage_q[0];
                stage_d[2] = stage_q[1];
                stage_d[3] = stage_q[2];
                stage_d[4] = stage_q[3];
                stage_d[5] = stage_q[4];
                stage_d[6] = stage_q[5];
                stage_d[7] = stage_q[6];
            end
            piso_pkg::PISO_HOLD: begin
                stage_d = stage_q;
            end
            default: begin
                stage_d = stage_q;
            end
        endcase
    end

    // Stages need no reset in use; zero only gives a defined start.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage_q <= piso_pkg::STAGE_RST;
        end else begin
            stage_q <= stage_d;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    // Separate flops so both pins change on the same edge.
    piso_pkg::piso_out_type out_q;
    piso_pkg::piso_out_type out_d;

    always_comb begin
        out_d.q_true = stage_d[7];
        out_d.q_comp = ~stage_d[7];
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_q <= piso_pkg::OUT_RST;
        end else begin
            out_q <= out_d;
        end
    end

    assign q_out = out_q;

endmodule

// ===== test/piso_shifter_properties.sv
// Checker: port properties of the shifter
`timescale 1ns/1ps
module piso_chk (
    // Clock and reset
    input wire logic                    clk,
    input wire logic                    arst_n,
    // Watched ports
    input wire piso_pkg::piso_ctrl_type ctrl,
    input wire logic [7:0]              par_data,
    input wire piso_pkg::piso_out_type  q_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire cmb = ctrl.shift_clk | ctrl.shift_clk_alt;
    a_out_comp: assert property (q_out.q_comp == !q_out.q_true)
        else $error("outputs not complementary");
    a_load_track: assert property ((!ctrl.load_n && $stable(par_data)) [*4] |->
        q_out.q_true == par_data[7]) else $error("load not followed");
    a_idle_keep: assert property ((ctrl.load_n && $stable(ctrl)) [*5] |->
        $stable(q_out)) else $error("state moved while idle");
    a_hold_block: assert property ((ctrl.load_n && ctrl.shift_clk_alt) [*5] |->
        $stable(q_out)) else $error("shift while held");
    // Guard on past load and reset: only shifts may move the output here
    a_shift_cause: assert property ($changed(q_out.q_true) && ctrl.load_n
        && $past(ctrl.load_n, 1) && $past(ctrl.load_n, 2) && $past(ctrl.load_n, 3)
        && $past(arst_n, 4) |-> $past(cmb, 3) && !$past(cmb, 4))
        else $error("output moved without clock rise");
    a_load_block: assert property ((!ctrl.load_n && $stable(par_data)) [*5] |->
        $stable(q_out)) else $error("output moved during load");
    c_alt_rise: cover property ($rose(ctrl.shift_clk_alt) && !ctrl.shift_clk);
    c_load: cover property ($fell(ctrl.load_n));
    c_both_high: cover property (ctrl.shift_clk && ctrl.shift_clk_alt);
endmodule
bind piso_shifter piso_chk i_chk (.clk(clk), .arst_n(arst_n), .ctrl(ctrl),
    .par_data(par_data), .q_out(q_out));

// ===== test/piso_ctrl_model.sv
// Controller model driving the shifter pins
`timescale 1ns/1ps
module piso_ctrl_model (
    // Clock
    input wire logic                clk,
    // Pins toward the shifter
    output piso_pkg::piso_ctrl_type ctrl,
    output logic [7:0]              par_data
);
    initial ctrl = 4'h8;
    initial par_data = 8'h00;
    // Each level stands 3 cycles so the synchronisers catch it
    task automatic step(input logic [3:0] c);
        ctrl <= c;
        repeat (3) @(posedge clk);
    endtask
    task automatic load(input logic [7:0] v);
        par_data <= v;
        step(4'h0);
        step(4'h0);
        step(4'h8);
        par_data <= ~v;
    endtask
    task automatic shift(input logic alt, input logic sd);
        step({3'b100, sd});
        step({1'b1, !alt, alt, sd});
        step({3'b100, sd});
    endtask
    // One shift, then inhibit raised while clock high
    task automatic hold();
        step(4'hc);
        step(4'he);
        step(4'ha);
        step(4'he);
        step(4'ha);
        step(4'h8);
    endtask
endmodule

// ===== test/tb_piso_shifter.sv
// Testbench for the parallel-in serial-out shifter
`timescale 1ns/1ps
module tb_piso_shifter;
    logic                    clk = 1'b0;
    logic                    arst_n = 1'b0;
    piso_pkg::piso_ctrl_type ctrl;
    logic [7:0]              par_data;
    piso_pkg::piso_out_type  q_out;
    int                      n_errors = 0;
    int                      cmp_count = 0;
    always #10 clk = !clk;
    piso_ctrl_model i_ctl (.clk(clk), .ctrl(ctrl), .par_data(par_data));
    piso_shifter i_dut (.clk(clk), .arst_n(arst_n), .ctrl(ctrl),
        .par_data(par_data), .q_out(q_out));
    task automatic chk(input string nm, input logic [1:0] s, input logic [1:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value %s expected %b seen %b", nm, e, s);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Word out first, serial byte behind it, clocks alternating
    task automatic t_shift(input logic [7:0] v, input logic [7:0] s);
        i_ctl.load(v);
        chk("load", q_out, {v[7], !v[7]});
        for (int k = 1; k < 16; k++) begin
            i_ctl.shift(k[0], (k <= 8) ? s[k-1] : 1'b0);
            chk("shift", q_out, (k < 8) ? {v[7-k], !v[7-k]} : {s[k-8], !s[k-8]});
        end
    endtask
    task automatic t_hold();
        i_ctl.load(8'h40);
        i_ctl.hold();
        chk("hold", q_out, 2'b10);
        repeat (200) @(posedge clk);
        chk("idle", q_out, 2'b10);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_shift(8'h96, 8'h5a);
        t_shift(8'h69, 8'ha5);
        t_hold();
        summarize();
    end
    // Run needs about 530 cycles
    initial begin
        repeat (2000) @(posedge clk);
        n_errors++;
        summarize();
    end
endmodule
